// File: hw/otrd_regs.sv
// Purpose: test-page offset trims, offset monitor and 48 kHz rate limits
// Assumes: byte register port synchronous to sys_clk, one-cycle strobes
// Notes:   read data registered, valid one cycle after the read strobe
//
// Functional notes
// - left common-mode trim byte, read/write, resets zero
// - common-mode trim code inverted quarter-millivolt steps
// - right differential trim byte, read/write, resets zero
// - right common-mode trim byte, same inverted coding
// - nine-bit left differential monitor across two bytes
// - monitor code non-inverted quarter-millivolt two's complement
// - five-bit minimum oscillator count limit field
// - five-bit maximum oscillator count limit field
// - locked page blocks writes, reads return zero, except the two unlock words
`timescale 1ns/100ps
`include "otrd_cfg.svh"
module otrd_regs
    import otrd_pkg::*;
(
    // clock and reset
    input  wire logic                          sys_clk,
    input  wire logic                          rst_b,
    // register port
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    input  wire logic [7:0]                    reg_addr,
    input  wire logic [7:0]                    reg_wdata,
    output logic      [7:0]                    reg_rdata,
    output logic                               reg_rvalid,
    // compensator side
    input  wire logic [`OTRD_MON_WIDTH-1:0]    left_differential_path_monitor,
    output logic      [7:0]                    left_cm_trim,
    output logic      [7:0]                    right_differential_path_trim,
    output logic      [7:0]                    right_cm_trim,
    // rate detector side
    input  wire logic                          count_valid,
    input  wire logic [`OTRD_COUNT_WIDTH-1:0]  osc_count,
    output logic                               rate_is_48k,
    output logic                               page_unlocked
);

    logic [7:0]                   unlock_word_first;
    logic [7:0]                   unlock_word_second;
    logic [`OTRD_LIMIT_WIDTH-1:0] rate48_min_limit;
    logic [`OTRD_LIMIT_WIDTH-1:0] rate48_max_limit;
    logic [`OTRD_MON_WIDTH-1:0]   monitor_live;
    logic [7:0]                   next_rdata;
    logic                         unlocked;
    logic                         page_wr;
    otrd_rate_type                rate_state;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [`OTRD_COUNT_WIDTH-1:0] widen_limit(input logic [`OTRD_LIMIT_WIDTH-1:0] f);
        widen_limit = {{(`OTRD_COUNT_WIDTH-`OTRD_LIMIT_WIDTH){1'b0}}, f};
    endfunction

    function automatic logic is_addr(input logic [7:0] a, input logic [7:0] b);
        is_addr = (a == b);
    endfunction

    // ****************************************
    // unlock words
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            unlock_word_first <= 8'h00;
        end else if (reg_wr && is_addr(reg_addr, `OTRD_ADDR_UNLOCK_FIRST)) begin
            unlock_word_first <= reg_wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            unlock_word_second <= 8'h00;
        end else if (reg_wr && is_addr(reg_addr, `OTRD_ADDR_UNLOCK_SEC)) begin
            unlock_word_second <= reg_wdata;
        end
    end

    assign unlocked = (unlock_word_first == `OTRD_UNLOCK_FIRST_VAL)
                   && (unlock_word_second == `OTRD_UNLOCK_SEC_VAL);
    assign page_wr  = reg_wr && unlocked;

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            page_unlocked <= 1'b0;
        end else begin
            page_unlocked <= unlocked;
        end
    end

    // ****************************************
    // manual offset trims
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            left_cm_trim <= `OTRD_TRIM_RESET;
        end else if (page_wr && is_addr(reg_addr, `OTRD_ADDR_L_CM_TRIM)) begin
            // code passes through untouched; inverted sense is analog side
            left_cm_trim <= reg_wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            right_differential_path_trim <= `OTRD_TRIM_RESET;
        end else if (page_wr && is_addr(reg_addr, `OTRD_ADDR_R_DIFFERENTIAL_PATH_TRIM)) begin
            // code passes through untouched; inverted sense is analog side
            right_differential_path_trim <= reg_wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            right_cm_trim <= `OTRD_TRIM_RESET;
        end else if (page_wr && is_addr(reg_addr, `OTRD_ADDR_R_CM_TRIM)) begin
            // code passes through untouched; inverted sense is analog side
            right_cm_trim <= reg_wdata;
        end
    end

    // ****************************************
    // rate limits
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            rate48_min_limit <= `OTRD_LIMIT_RESET;
        end else if (page_wr && is_addr(reg_addr, `OTRD_ADDR_MIN_COUNT)) begin
            rate48_min_limit <= reg_wdata[`OTRD_LIMIT_WIDTH-1:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            rate48_max_limit <= `OTRD_LIMIT_RESET;
        end else if (page_wr && is_addr(reg_addr, `OTRD_ADDR_MAX_COUNT)) begin
            rate48_max_limit <= reg_wdata[`OTRD_LIMIT_WIDTH-1:0];
        end
    end

    // ****************************************
    // monitor capture
    // ****************************************
    // sampled each cycle, never written by the port
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            monitor_live <= '0;
        end else begin
            monitor_live <= left_differential_path_monitor;
        end
    end

    // ****************************************
    // read mux
    // ****************************************
    always_comb begin
        next_rdata = 8'h00;
        if (is_addr(reg_addr, `OTRD_ADDR_UNLOCK_FIRST)) begin
            next_rdata = unlock_word_first;
        end else if (is_addr(reg_addr, `OTRD_ADDR_UNLOCK_SEC)) begin
            next_rdata = unlock_word_second;
        end else if (!unlocked) begin
            next_rdata = 8'h00;
        end else if (is_addr(reg_addr, `OTRD_ADDR_L_CM_TRIM)) begin
            next_rdata = left_cm_trim;
        end else if (is_addr(reg_addr, `OTRD_ADDR_R_DIFFERENTIAL_PATH_TRIM)) begin
            next_rdata = right_differential_path_trim;
        end else if (is_addr(reg_addr, `OTRD_ADDR_R_CM_TRIM)) begin
            next_rdata = right_cm_trim;
        end else if (is_addr(reg_addr, `OTRD_ADDR_MON_HIGH)) begin
            next_rdata = {7'h00, monitor_live[8]};
        end else if (is_addr(reg_addr, `OTRD_ADDR_MON_LOW)) begin
            next_rdata = monitor_live[7:0];
        end else if (is_addr(reg_addr, `OTRD_ADDR_MIN_COUNT)) begin
            next_rdata = {3'h0, rate48_min_limit};
        end else if (is_addr(reg_addr, `OTRD_ADDR_MAX_COUNT)) begin
            next_rdata = {3'h0, rate48_max_limit};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
        end
    end

    // read data holds until the next read
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end

    // ****************************************
    // rate detection
    // ****************************************
    otrd_rate_window u_rate_window (
        .sys_clk     (sys_clk),
        .rst_b       (rst_b),
        .count_valid (count_valid),
        .osc_count   (osc_count),
        .min_limit   (widen_limit(rate48_min_limit)),
        .max_limit   (widen_limit(rate48_max_limit)),
        .rate_state  (rate_state)
    );

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            rate_is_48k <= 1'b0;
        end else begin
            rate_is_48k <= (rate_state == OTRD_RATE_IS_48K);
        end
    end

endmodule

// File: hw/otrd_cfg.svh
// Purpose: constants for the offset trim and rate detect register slice
// Assumes: byte-wide register port, 8-bit page offsets
// Notes:   offsets are byte addresses within the test page
`ifndef OTRD_CFG_SVH
`define OTRD_CFG_SVH

// ****************************************
// register offsets
// ****************************************
`define OTRD_ADDR_L_CM_TRIM    8'h47
`define OTRD_ADDR_R_DIFFERENTIAL_PATH_TRIM  8'h48
`define OTRD_ADDR_R_CM_TRIM    8'h49
`define OTRD_ADDR_RSVD_A       8'h4a
`define OTRD_ADDR_RSVD_B       8'h4b
`define OTRD_ADDR_MON_HIGH     8'h4c
`define OTRD_ADDR_MON_LOW      8'h4d
`define OTRD_ADDR_MIN_COUNT    8'h4e
`define OTRD_ADDR_RSVD_C       8'h4f
`define OTRD_ADDR_MAX_COUNT    8'h50
`define OTRD_ADDR_RSVD_D       8'h51
`define OTRD_ADDR_UNLOCK_FIRST 8'h3f
`define OTRD_ADDR_UNLOCK_SEC   8'h40

// ****************************************
// fields and reset values
// ****************************************
`define OTRD_TRIM_RESET        8'h00
`define OTRD_LIMIT_WIDTH       5
`define OTRD_LIMIT_RESET       5'h00
`define OTRD_MON_WIDTH         9
`define OTRD_COUNT_WIDTH       12
`define OTRD_MIN_COUNT_DOC     12'd863
`define OTRD_MAX_COUNT_DOC     12'd2479
`define OTRD_UNLOCK_FIRST_VAL  8'h5a
`define OTRD_UNLOCK_SEC_VAL    8'ha5

`endif

// File: hw/otrd_pkg.sv
// Purpose: types for the offset trim and rate detect register slice
// Assumes: nothing
// Notes:   constants live in otrd_cfg.svh
package otrd_pkg;
    typedef enum logic [1:0] {
        OTRD_RATE_UNKNOWN,
        OTRD_RATE_IS_48K,
        OTRD_RATE_OTHER
    } otrd_rate_type;
endpackage

// File: hw/otrd_rate_window.sv
// Purpose: inclusive window check of a measured oscillator count
// Assumes: limits already widened to count width
// Notes:   result registered
`timescale 1ns/100ps
`include "otrd_cfg.svh"
module otrd_rate_window
    import otrd_pkg::*;
(
    // clock and reset
    input  wire logic                          sys_clk,
    input  wire logic                          rst_b,
    // measurement
    input  wire logic                          count_valid,
    input  wire logic [`OTRD_COUNT_WIDTH-1:0]  osc_count,
    input  wire logic [`OTRD_COUNT_WIDTH-1:0]  min_limit,
    input  wire logic [`OTRD_COUNT_WIDTH-1:0]  max_limit,
    // result
    output otrd_rate_type                      rate_state
);

    // ****************************************
    // window compare
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            rate_state <= OTRD_RATE_UNKNOWN;
        end else if (count_valid) begin
            if (osc_count >= min_limit && osc_count <= max_limit) begin
                rate_state <= OTRD_RATE_IS_48K;
            end else begin
                rate_state <= OTRD_RATE_OTHER;
            end
        end
    end

endmodule

// File: tb/otrd_regs_asserts.sv
// Purpose: port checks of otrd_regs
// Assumes: page_unlocked lags the unlock state by one cycle
// Notes: bind at the foot
`timescale 1ns/100ps
module otrd_regs_chk
    import otrd_pkg::*;
(
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        rst_b,
    // register port
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic [7:0]  reg_rdata,
    input wire logic        reg_rvalid,
    // far sides
    input wire logic [8:0]  left_differential_path_monitor,
    input wire logic [7:0]  left_cm_trim,
    input wire logic [7:0]  right_differential_path_trim,
    input wire logic [7:0]  right_cm_trim,
    input wire logic        count_valid,
    input wire logic [11:0] osc_count,
    input wire logic        rate_is_48k,
    input wire logic        page_unlocked
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    logic pw_q;
    wire  pw = reg_wr && reg_addr inside {8'h3f, 8'h40};
    wire  pg = reg_addr inside {[8'h47:8'h51]};
    wire  op = page_unlocked && !pw_q;
    always_ff @(posedge sys_clk) pw_q <= pw;
    property p_lrd; reg_rd && pg ##1 !page_unlocked |-> reg_rdata == 8'h00; endproperty
    a_lrd: assert property (p_lrd) else $error("locked read not zero");
    property p_lwr; reg_wr && pg ##1 !page_unlocked |-> $stable({left_cm_trim, right_differential_path_trim, right_cm_trim}); endproperty
    a_lwr: assert property (p_lwr) else $error("locked write changed a trim");
    property p_lcm; reg_wr && reg_addr == 8'h47 && op |=> left_cm_trim == $past(reg_wdata); endproperty
    a_lcm: assert property (p_lcm) else $error("left cm trim not written");
    property p_rdf; reg_wr && reg_addr == 8'h48 && op |=> right_differential_path_trim == $past(reg_wdata); endproperty
    a_rdf: assert property (p_rdf) else $error("right differential_path trim not written");
    property p_rcm; reg_wr && reg_addr == 8'h49 && op |=> right_cm_trim == $past(reg_wdata); endproperty
    a_rcm: assert property (p_rcm) else $error("right cm trim not written");
    property p_mlo; reg_rd && reg_addr == 8'h4d && op && $stable(left_differential_path_monitor)
        |=> reg_rdata == $past(left_differential_path_monitor[7:0]); endproperty
    a_mlo: assert property (p_mlo) else $error("monitor low byte wrong");
    property p_mhi; reg_rd && reg_addr == 8'h4c && op && $stable(left_differential_path_monitor)
        |=> reg_rdata == {7'h00, $past(left_differential_path_monitor[8])}; endproperty
    a_mhi: assert property (p_mhi) else $error("monitor high byte wrong");
    property p_rate; $changed(rate_is_48k) |-> $past(count_valid, 2); endproperty
    a_rate: assert property (p_rate) else $error("rate flag moved without a count");
    c_unl: cover property ($rose(page_unlocked));
    c_rate: cover property ($rose(rate_is_48k));
    c_mon: cover property (reg_rd && reg_addr == 8'h4d && op);
endmodule
bind otrd_regs otrd_regs_chk u_chk (.sys_clk, .rst_b, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .reg_rvalid, .left_differential_path_monitor, .left_cm_trim, .right_differential_path_trim, .right_cm_trim, .count_valid,
    .osc_count, .rate_is_48k, .page_unlocked);

// File: tb/otrd_comp_model.sv
// Purpose: compensator and rate counter stand-in
// Assumes: bench sets values ahead of use
// Notes: count lines toggle while no measurement stands
`timescale 1ns/100ps
module otrd_comp_model (
    input wire logic        sys_clk,
    input wire logic        rst_b,
    input wire logic [8:0]  mon_set,
    input wire logic        meas_go,
    input wire logic [11:0] meas_set,
    output logic     [8:0]  left_differential_path_monitor,
    output logic            count_valid,
    output logic     [11:0] osc_count
);
    always_ff @(posedge sys_clk) begin
        left_differential_path_monitor <= mon_set;
        count_valid <= meas_go && rst_b;
        osc_count <= meas_go ? meas_set : (rst_b ? ~osc_count : 12'h000);
    end
endmodule

// File: tb/test_otrd_regs.sv
// Purpose: register port test of otrd_regs
// Assumes: unlock words of otrd_cfg.svh
// Notes: compensator side from otrd_comp_model
`timescale 1ns/100ps
`include "otrd_cfg.svh"
module test_offset_trim_and_rate_detect_regs;
    logic sys_clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, meas_go = 0, reg_rvalid, count_valid;
    logic rate_is_48k, page_unlocked;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, left_cm_trim, right_differential_path_trim, right_cm_trim;
    logic [8:0] mon_set = 9'h000, left_differential_path_monitor;
    logic [11:0] meas_set = 12'h000, osc_count;
    int errors = 0, checks = 0;
    always #12.5 sys_clk = ~sys_clk;
    otrd_comp_model model (.sys_clk, .rst_b, .mon_set, .meas_go, .meas_set, .left_differential_path_monitor, .count_valid,
        .osc_count);
    otrd_regs dut (.sys_clk, .rst_b, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid,
        .left_differential_path_monitor, .left_cm_trim, .right_differential_path_trim, .right_cm_trim, .count_valid, .osc_count,
        .rate_is_48k, .page_unlocked);
    task finish_test;
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        int n;
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        for (n = 0; n < 4 && reg_rvalid !== 1'b1; n++) @(posedge sys_clk) #1;
        chk("reg_rvalid", 8'h01, {7'h00, reg_rvalid});
        if (n == 4) finish_test;
        chk("reg_rdata", e, reg_rdata);
    endtask
    task meas(input logic [11:0] c, input logic e);
        @(posedge sys_clk);
        meas_go <= 1'b1;
        meas_set <= c;
        @(posedge sys_clk);
        meas_go <= 1'b0;
        repeat (4) @(posedge sys_clk) #1;
        chk("rate_is_48k", {7'h00, e}, {7'h00, rate_is_48k});
    endtask
    task mon(input logic [8:0] v);
        @(posedge sys_clk) mon_set <= v;
        repeat (3) @(posedge sys_clk);
    endtask
    initial begin
        repeat (10) @(posedge sys_clk);
        rst_b <= 1'b1;
        wr(8'h47, 8'h33);
        rd(8'h47, 8'h00);
        chk("left_cm_trim", 8'h00, left_cm_trim);
        wr(`OTRD_ADDR_UNLOCK_FIRST, `OTRD_UNLOCK_FIRST_VAL);
        wr(`OTRD_ADDR_UNLOCK_SEC, `OTRD_UNLOCK_SEC_VAL);
        rd(`OTRD_ADDR_UNLOCK_FIRST, `OTRD_UNLOCK_FIRST_VAL);
        chk("page_unlocked", 8'h01, {7'h00, page_unlocked});
        for (int i = 0; i < 3; i++) begin
            rd(8'(8'h47 + i), 8'h00);
            wr(8'(8'h47 + i), 8'(24'h40413f >> (8 * i)));
            rd(8'(8'h47 + i), 8'(24'h40413f >> (8 * i)));
        end
        chk("left_cm_trim", 8'h3f, left_cm_trim);
        chk("right_differential_path_trim", 8'h41, right_differential_path_trim);
        chk("right_cm_trim", 8'h40, right_cm_trim);
        for (int i = 0; i < 4; i++) begin
            wr(8'(32'h514f4b4a >> (8 * i)), 8'hff);
            rd(8'(32'h514f4b4a >> (8 * i)), 8'h00);
        end
        wr(8'h4e, 8'hff);
        rd(8'h4e, 8'h1f);
        wr(8'h50, 8'hff);
        rd(8'h50, 8'h1f);
        wr(8'h4e, 8'h05);
        wr(8'h50, 8'h0a);
        meas(12'd4, 1'b0);
        meas(12'd5, 1'b1);
        meas(12'd11, 1'b0);
        meas(12'd10, 1'b1);
        meas(12'h805, 1'b0);
        mon(9'h0ff);
        rd(8'h4c, 8'h00);
        rd(8'h4d, 8'hff);
        mon(9'h101);
        wr(8'h4d, 8'h00);
        rd(8'h4c, 8'h01);
        rd(8'h4d, 8'h01);
        wr(`OTRD_ADDR_UNLOCK_FIRST, 8'h00);
        rd(8'h47, 8'h00);
        chk("page_unlocked", 8'h00, {7'h00, page_unlocked});
        // mid-run reset, then trims and limits back at zero
        @(posedge sys_clk) rst_b <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk) #1;
        chk("right_cm_trim", 8'h00, right_cm_trim);
        wr(`OTRD_ADDR_UNLOCK_FIRST, `OTRD_UNLOCK_FIRST_VAL);
        wr(`OTRD_ADDR_UNLOCK_SEC, `OTRD_UNLOCK_SEC_VAL);
        for (int i = 0; i < 3; i++) begin
            rd(8'(8'h47 + i), 8'h00);
        end
        rd(8'h4e, 8'h00);
        rd(8'h50, 8'h00);
        finish_test;
    end
endmodule
